// [hdl/pms_pkg.sv]
// Shared constants and types for the power module management bus slave
package pms_pkg;

  // Command codes
  localparam logic [7:0] CMD_OUT_ON_OFF = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_SRC = 8'h02;
  localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CMD_SAVE_FACTORY = 8'h11;
  localparam logic [7:0] CMD_LOAD_FACTORY = 8'h12;
  localparam logic [7:0] CMD_SAVE_USER = 8'h15;
  localparam logic [7:0] CMD_LOAD_USER = 8'h16;
  localparam logic [7:0] CMD_FEATURES = 8'h19;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CMD_OUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_SETPOINT = 8'h21;

  // Reset and fixed values
  localparam logic [7:0] RST_OUT_ON_OFF = 8'h00;
  localparam logic [7:0] RST_ON_OFF_SRC = 8'h16;
  localparam logic [7:0] RST_WRITE_LOCK = 8'h00;
  localparam logic [7:0] RST_ALERT_MASK = 8'h08;
  localparam logic [15:0] RST_SETPOINT = 16'h0100;
  localparam logic [7:0] FEATURES_VAL = 8'hB0;
  localparam logic [7:0] OUT_FORMAT_VAL = 8'h17;

  // On/off source configuration fields
  localparam int ONOFF_USE_CFG_BIT = 4;
  localparam int ONOFF_CMD_BIT = 3;
  localparam int ONOFF_PIN_BIT = 2;
  localparam int ONOFF_POL_BIT = 1;
  localparam int OP_ON_BIT = 7;

  // Write lock levels
  localparam logic [7:0] LOCK_ALL = 8'h80;
  localparam logic [7:0] LOCK_BUT_OP = 8'h40;
  localparam logic [7:0] LOCK_BUT_SET = 8'h20;
  localparam logic [7:0] LOCK_NONE = 8'h00;

  // Addressing
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [6:0] FALLBACK_ADDR = 7'h7F;
  localparam logic [3:0] STRAP_MAX = 4'h7;
  localparam logic [6:0] STRAP_RADIX = 7'h08;

  // Status and packet check
  localparam int STAT_POWER_GOOD_STATUS_BIT = 3;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [2:0] WLEN_NONE = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Bus rates the slave is built for, in kHz
  localparam int BUS_STD_KHZ = 100;
  localparam int BUS_FAST_KHZ = 400;

  typedef struct packed {
    logic [7:0] on_off_src;
    logic [7:0] write_lock;
    logic [7:0] alert_mask;
    logic [15:0] setpoint;
  } pms_store_t;

  localparam pms_store_t STORE_RST = '{
    on_off_src: RST_ON_OFF_SRC,
    write_lock: RST_WRITE_LOCK,
    alert_mask: RST_ALERT_MASK,
    setpoint: RST_SETPOINT
  };

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } pms_state_t;

endpackage : pms_pkg

// [hdl/pms_slave.sv]
// Management bus slave: framing, command registers, on/off and alert logic
`timescale 1ns/1ps
module pms_slave
  import pms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic bus_clk,
  input wire logic bus_data_in,
  output logic bus_data_out,
  output logic bus_data_oe,
  output logic alert_out,
  output logic alert_oe,
  input wire logic remote_on_off_input,
  input wire logic [3:0] address_strap_high_digit,
  input wire logic [3:0] address_strap_low_digit,
  input wire logic power_good_status,
  input wire logic [7:0] fault_set,
  output logic conversion_enable,
  output logic [15:0] vout_setpoint,
  output logic [7:0] fault_status
);

  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  function automatic logic [7:0] gray2bin(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // Write length in data bytes, or WLEN_NONE for unknown commands
  function automatic logic [2:0] cmd_wlen(input logic [7:0] cmd);
    case (cmd)
      CMD_FAULT_CLEAR, CMD_SAVE_FACTORY, CMD_LOAD_FACTORY,
      CMD_SAVE_USER, CMD_LOAD_USER: return 3'h0;
      CMD_OUT_ON_OFF, CMD_ON_OFF_SRC, CMD_WRITE_LOCK, CMD_ALERT_MASK,
      CMD_FEATURES, CMD_OUT_FORMAT: return 3'h1;
      CMD_SETPOINT: return 3'h2;
      default: return WLEN_NONE;
    endcase
  endfunction : cmd_wlen

  function automatic logic lock_allows(input logic [7:0] lock, input logic [7:0] cmd);
    case (lock)
      LOCK_ALL: return cmd == CMD_WRITE_LOCK;
      LOCK_BUT_OP: return cmd == CMD_WRITE_LOCK || cmd == CMD_OUT_ON_OFF;
      LOCK_BUT_SET: return cmd == CMD_WRITE_LOCK || cmd == CMD_OUT_ON_OFF ||
                           cmd == CMD_ON_OFF_SRC || cmd == CMD_SETPOINT;
      default: return 1'b1;
    endcase
  endfunction : lock_allows

  // ---------------- Link domain (bus clock) ----------------
  logic link_clr_r;
  logic [7:0] rx_sh_l;
  logic [7:0] cnt_l;
  logic [7:0] gray_l;
  logic [7:0] cnt_inc;
  logic sda_low_l;
  logic tx_low_r;

  // Link flops are cleared asynchronously since the bus clock may stand still in reset
  always_ff @(posedge clk_sys) begin
    link_clr_r <= ~resetn;
  end

  assign cnt_inc = cnt_l + 8'h01;

  // Data sampled on the rising bus clock, MSB arrives first
  always_ff @(posedge bus_clk or posedge link_clr_r) begin
    if (link_clr_r) begin
      rx_sh_l <= 8'h00;
      cnt_l <= 8'h00;
      gray_l <= 8'h00;
    end else begin
      rx_sh_l <= {rx_sh_l[6:0], bus_data_in};
      cnt_l <= cnt_inc;
      gray_l <= cnt_inc ^ (cnt_inc >> 1);
    end
  end

  // Data line changes only while the clock is low; tx_low_r is steady by then
  always_ff @(negedge bus_clk or posedge link_clr_r) begin
    if (link_clr_r) begin
      sda_low_l <= 1'b0;
    end else begin
      sda_low_l <= tx_low_r;
    end
  end

  // Open drain data; there is no clock output, so no stretching is possible
  assign bus_data_out = 1'b0;
  assign bus_data_oe = sda_low_l;

  // ---------------- System domain ----------------
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [7:0] gray_s1;
  logic [7:0] gray_s2;
  logic [7:0] cnt_sys;
  logic [7:0] seen_r;
  logic start_det;
  logic stop_det;
  logic step;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      gray_s1 <= 8'h00;
      gray_s2 <= 8'h00;
    end else begin
      scl_s <= {scl_s[1:0], bus_clk};
      sda_s <= {sda_s[1:0], bus_data_in};
      gray_s1 <= gray_l;
      gray_s2 <= gray_s1;
    end
  end

  // 50 MHz oversampling leaves >25 samples per clock phase even at 400 kHz
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign cnt_sys = gray2bin(gray_s2);
  assign step = cnt_sys != seen_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seen_r <= 8'h00;
    end else if (start_det) begin
      seen_r <= cnt_sys;
    end else if (step) begin
      seen_r <= seen_r + 8'h01;
    end
  end

  // Address straps caught once after reset release
  logic [3:0] strap_hi_s1, strap_hi_s2, strap_lo_s1, strap_lo_s2;
  logic strap_done_r;
  logic [6:0] own_addr_r;

  // No reset here: a cleared stage would be latched as address zero on release
  always_ff @(posedge clk_sys) begin
    strap_hi_s1 <= address_strap_high_digit;
    strap_hi_s2 <= strap_hi_s1;
    strap_lo_s1 <= address_strap_low_digit;
    strap_lo_s2 <= strap_lo_s1;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strap_done_r <= 1'b0;
      own_addr_r <= FALLBACK_ADDR;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      if (strap_hi_s2 > STRAP_MAX || strap_lo_s2 > STRAP_MAX) begin
        own_addr_r <= FALLBACK_ADDR;
      end else begin
        own_addr_r <= STRAP_RADIX * {3'h0, strap_hi_s2} + {3'h0, strap_lo_s2};
      end
    end
  end

  // Protocol engine
  pms_state_t state_r;
  pms_state_t nxt_r;
  logic [3:0] pos_r;
  logic [3:0] pos_p1;
  logic ack_r;
  logic ara_r;
  logic ara_hit;
  logic wr_active_r;
  logic [7:0] cmd_r;
  logic [2:0] nwr_r;
  logic [15:0] wbuf_r;
  logic [7:0] crc_r;
  logic [7:0] tx_byte_r;
  logic [2:0] rd_idx_r;
  logic [7:0] rd_byte;
  logic [15:0] rd_val;
  logic [2:0] rd_len;
  logic [2:0] wl;
  logic alert_req;
  pms_store_t cur_r;
  logic [7:0] out_on_off_r;

  assign pos_p1 = pos_r + 4'h1;
  assign wl = cmd_wlen(cmd_r);

  // Read value and length per command; write-only and unknown read as idle bus
  always_comb begin
    rd_val = 16'h0000;
    rd_len = 3'h1;
    case (cmd_r)
      CMD_OUT_ON_OFF: rd_val = {8'h00, out_on_off_r};
      CMD_ON_OFF_SRC: rd_val = {8'h00, cur_r.on_off_src};
      CMD_WRITE_LOCK: rd_val = {8'h00, cur_r.write_lock};
      CMD_ALERT_MASK: rd_val = {8'h00, cur_r.alert_mask};
      CMD_FEATURES: rd_val = {8'h00, FEATURES_VAL};
      CMD_OUT_FORMAT: rd_val = {8'h00, OUT_FORMAT_VAL};
      CMD_SETPOINT: begin
        rd_val = cur_r.setpoint;
        rd_len = 3'h2;
      end
      default: rd_len = 3'h0;
    endcase
  end

  // Low byte goes out first, then the packet check byte if clocked
  always_comb begin
    rd_byte = 8'hFF;
    if (ara_r) begin
      if (rd_idx_r == 3'h0) begin
        rd_byte = {own_addr_r, 1'b0};
      end else if (rd_idx_r == 3'h1) begin
        rd_byte = crc_r;
      end
    end else if (rd_idx_r < rd_len) begin
      rd_byte = rd_idx_r[0] ? rd_val[15:8] : rd_val[7:0];
    end else if (rd_idx_r == rd_len && rd_len != 3'h0) begin
      rd_byte = crc_r;
    end
  end

  assign ara_hit = step && pos_r != BITS_PER_BYTE && pos_p1 == BITS_PER_BYTE &&
                   state_r == ST_ADDR && rx_sh_l[0] &&
                   rx_sh_l[7:1] == ALERT_RESP_ADDR && rx_sh_l[7:1] != own_addr_r && alert_req;

  // rx_sh_l is read only after its change is seen through the gray sync, so it is stable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      nxt_r <= ST_IDLE;
      pos_r <= 4'h0;
      ack_r <= 1'b0;
      ara_r <= 1'b0;
      wr_active_r <= 1'b0;
      cmd_r <= 8'h00;
      nwr_r <= 3'h0;
      wbuf_r <= 16'h0000;
      crc_r <= 8'h00;
      tx_byte_r <= 8'hFF;
      rd_idx_r <= 3'h0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      pos_r <= 4'h0;
      crc_r <= 8'h00;
      wr_active_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      pos_r <= 4'h0;
    end else if (step && state_r != ST_IDLE) begin
      if (pos_r == BITS_PER_BYTE) begin
        pos_r <= 4'h0;
        if (state_r == ST_RDATA) begin
          if (rx_sh_l[0]) begin
            state_r <= ST_SKIP;
          end else begin
            tx_byte_r <= rd_byte;
            rd_idx_r <= rd_idx_r + 3'h1;
          end
        end else if (state_r != ST_SKIP) begin
          state_r <= ack_r ? nxt_r : ST_SKIP;
          if (ack_r && nxt_r == ST_RDATA) begin
            tx_byte_r <= rd_byte;
            rd_idx_r <= rd_idx_r + 3'h1;
          end
        end
      end else begin
        pos_r <= pos_p1;
        if (pos_p1 == BITS_PER_BYTE) begin
          case (state_r)
            ST_ADDR: begin
              crc_r <= crc8(crc_r, rx_sh_l);
              rd_idx_r <= 3'h0;
              if (rx_sh_l[7:1] == own_addr_r) begin
                ack_r <= 1'b1;
                ara_r <= 1'b0;
                wr_active_r <= ~rx_sh_l[0];
                nxt_r <= rx_sh_l[0] ? ST_RDATA : ST_CMD;
              end else if (ara_hit) begin
                ack_r <= 1'b1;
                ara_r <= 1'b1;
                wr_active_r <= 1'b0;
                nxt_r <= ST_RDATA;
              end else begin
                ack_r <= 1'b0;
              end
            end
            ST_CMD: begin
              crc_r <= crc8(crc_r, rx_sh_l);
              cmd_r <= rx_sh_l;
              nwr_r <= 3'h0;
              ack_r <= 1'b1;
              nxt_r <= ST_WDATA;
            end
            ST_WDATA: begin
              crc_r <= crc8(crc_r, rx_sh_l);
              // Unknown commands and surplus bytes are refused
              ack_r <= wl != WLEN_NONE && nwr_r <= wl;
              nxt_r <= ST_WDATA;
              if (wl != WLEN_NONE && nwr_r <= wl) begin
                nwr_r <= nwr_r + 3'h1;
                if (nwr_r == 3'h0) begin
                  wbuf_r[7:0] <= rx_sh_l;
                end else if (nwr_r == 3'h1) begin
                  wbuf_r[15:8] <= rx_sh_l;
                end
              end
            end
            ST_RDATA: crc_r <= crc8(crc_r, tx_byte_r);
            default: ack_r <= 1'b0;
          endcase
        end
      end
    end
  end

  // Next level for the data line, latched by the link on the falling clock
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_low_r <= 1'b0;
    end else if (state_r == ST_RDATA && pos_r < BITS_PER_BYTE) begin
      tx_low_r <= ~tx_byte_r[3'h7 - pos_r[2:0]];
    end else if ((state_r == ST_ADDR || state_r == ST_CMD || state_r == ST_WDATA) &&
                 pos_r == BITS_PER_BYTE) begin
      tx_low_r <= ack_r;
    end else begin
      tx_low_r <= 1'b0;
    end
  end

  // Write commit at STOP; a clocked check byte must match
  logic commit;
  logic commit_ok;
  logic clear_faults;
  assign commit = stop_det && wr_active_r && state_r == ST_WDATA;
  assign commit_ok = commit && wl != WLEN_NONE &&
                     (nwr_r == wl || (nwr_r == wl + 3'h1 && crc_r == 8'h00));
  assign clear_faults = commit_ok && cmd_r == CMD_FAULT_CLEAR;

  pms_store_t factory_slot_r;
  pms_store_t user_slot_r;

  // Save slots change only on explicit store commands
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      factory_slot_r <= STORE_RST;
      user_slot_r <= STORE_RST;
    end else if (commit_ok && cmd_r == CMD_SAVE_FACTORY) begin
      factory_slot_r <= cur_r;
    end else if (commit_ok && cmd_r == CMD_SAVE_USER) begin
      user_slot_r <= cur_r;
    end
  end

  // Operating settings; read-only commands fall through untouched
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cur_r <= STORE_RST;
      out_on_off_r <= RST_OUT_ON_OFF;
    end else if (commit_ok && lock_allows(cur_r.write_lock, cmd_r)) begin
      case (cmd_r)
        CMD_OUT_ON_OFF: out_on_off_r <= wbuf_r[7:0];
        CMD_ON_OFF_SRC: cur_r.on_off_src <= wbuf_r[7:0];
        CMD_WRITE_LOCK: cur_r.write_lock <= wbuf_r[7:0];
        CMD_ALERT_MASK: cur_r.alert_mask <= wbuf_r[7:0];
        CMD_SETPOINT: cur_r.setpoint <= wbuf_r;
        CMD_LOAD_FACTORY: begin
          if (cur_r.write_lock == LOCK_NONE) begin
            cur_r <= factory_slot_r;
          end
        end
        CMD_LOAD_USER: begin
          if (cur_r.write_lock == LOCK_NONE) begin
            cur_r <= user_slot_r;
          end
        end
        default: cur_r <= cur_r;
      endcase
    end
  end

  // Fault status and alert
  logic [7:0] fault_s1, fault_s2;
  logic power_good_status_s1, power_good_status_s2, onoff_s1, onoff_s2;
  logic [7:0] events;
  logic [7:0] status_r;
  logic ara_done_r;
  logic alert_oe_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fault_s1 <= 8'h00;
      fault_s2 <= 8'h00;
      power_good_status_s1 <= 1'b1;
      power_good_status_s2 <= 1'b1;
      onoff_s1 <= 1'b0;
      onoff_s2 <= 1'b0;
    end else begin
      fault_s1 <= fault_set;
      fault_s2 <= fault_s1;
      power_good_status_s1 <= power_good_status;
      power_good_status_s2 <= power_good_status_s1;
      onoff_s1 <= remote_on_off_input;
      onoff_s2 <= onoff_s1;
    end
  end

  always_comb begin
    events = fault_s2;
    events[STAT_POWER_GOOD_STATUS_BIT] = fault_s2[STAT_POWER_GOOD_STATUS_BIT] | ~power_good_status_s2;
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status_r <= 8'h00;
    end else begin
      status_r <= (clear_faults ? 8'h00 : status_r) | events;
    end
  end

  // Line released as soon as the alert response address is received, before our address goes out
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ara_done_r <= 1'b0;
    end else if (ara_hit) begin
      ara_done_r <= 1'b1;
    end else if (clear_faults || |(events & ~status_r)) begin
      ara_done_r <= 1'b0;
    end
  end

  assign alert_req = |(status_r & ~cur_r.alert_mask) & ~ara_done_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alert_oe_r <= 1'b0;
    end else begin
      alert_oe_r <= alert_req & ~clear_faults;
    end
  end

  assign alert_out = 1'b0;
  assign alert_oe = alert_oe_r;

  // On/off combination
  logic conv_en_r;
  logic pin_ok;
  logic cmd_ok;
  assign pin_ok = ~cur_r.on_off_src[ONOFF_PIN_BIT] |
                  (onoff_s2 == cur_r.on_off_src[ONOFF_POL_BIT]);
  assign cmd_ok = ~cur_r.on_off_src[ONOFF_CMD_BIT] | out_on_off_r[OP_ON_BIT];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      conv_en_r <= 1'b0;
    end else begin
      conv_en_r <= ~cur_r.on_off_src[ONOFF_USE_CFG_BIT] | (pin_ok & cmd_ok);
    end
  end

  assign conversion_enable = conv_en_r;
  assign vout_setpoint = cur_r.setpoint;
  assign fault_status = status_r;

endmodule : pms_slave

// [test/pms_monitor.sv]
// Port-level checks for the management bus slave
`timescale 1ns/1ps
module pms_monitor
  import pms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic bus_clk,
  input wire logic bus_data_out,
  input wire logic bus_data_oe,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic power_good_status,
  input wire logic [7:0] fault_set,
  input wire logic [15:0] vout_setpoint,
  input wire logic [7:0] fault_status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_sda_od; bus_data_out == 1'b0; endproperty
  a_sda_od: assert property (p_sda_od) else $error("data out not low");
  property p_alt_od; alert_out == 1'b0; endproperty
  a_alt_od: assert property (p_alt_od) else $error("alert out not low");
  // Data may only move while the bus clock is low
  property p_sda_chg; $changed(bus_data_oe) |-> !bus_clk; endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("data moved, clock high");
  property p_flt_set; fault_set[0] [*5] |-> fault_status[0]; endproperty
  a_flt_set: assert property (p_flt_set) else $error("fault bit not set");
  property p_pg_set; !power_good_status [*5] |-> fault_status[STAT_POWER_GOOD_STATUS_BIT]; endproperty
  a_pg_set: assert property (p_pg_set) else $error("power-good bit not set");
  property p_alert; $rose(alert_oe) |-> fault_status != 8'h00; endproperty
  a_alert: assert property (p_alert) else $error("alert with no status");
  property p_sp_commit; $changed(vout_setpoint) |-> bus_clk; endproperty
  a_sp_commit: assert property (p_sp_commit) else $error("setpoint moved mid-frame");
  property p_clr; $fell(fault_status[0]) |-> bus_clk; endproperty
  a_clr: assert property (p_clr) else $error("status cleared mid-frame");
  c_alert: cover property ($rose(alert_oe));
  c_sp: cover property ($changed(vout_setpoint));
  c_clr: cover property ($fell(fault_status[0]));
endmodule : pms_monitor

// [test/pms_host.sv]
// Bus host model driving clock and open-drain data
`timescale 1ns/1ps
module pms_host (
  output logic bus_clk,
  output logic host_oe,
  input wire logic sda
);
  int half_ns = 250; // Rate set per transfer by the bench
  initial begin
    bus_clk = 1'b1; // Clock stands high between frames
    host_oe = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    host_oe = ~b;
    #(half_ns / 2);
    bus_clk = 1'b1;
    #(half_ns);
    r = sda;
    bus_clk = 1'b0;
    #(half_ns / 2);
  endtask : bit_io
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
  endtask : xbyte
  task automatic start;
    host_oe = 1'b0;
    #(half_ns / 2);
    bus_clk = 1'b1;
    #(half_ns / 2);
    host_oe = 1'b1;
    #(half_ns / 2);
    bus_clk = 1'b0;
    #(half_ns / 2);
  endtask : start
  task automatic stop;
    host_oe = 1'b1;
    #(half_ns / 2);
    bus_clk = 1'b1;
    #(half_ns / 2);
    host_oe = 1'b0;
    #(half_ns);
  endtask : stop
endmodule : pms_host

// [test/testbench.sv]
// Self-checking bench for the management bus slave
`timescale 1ns/1ps
module testbench;
  import pms_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic remote_on_off_input = 1'b1;
  logic [3:0] address_strap_high_digit = 4'h0;
  logic [3:0] address_strap_low_digit = 4'h0;
  logic power_good_status = 1'b1;
  logic [7:0] fault_set = 8'h00;
  logic bus_clk, bus_data_out, bus_data_oe, alert_out, alert_oe, host_oe, conversion_enable;
  logic [15:0] vout_setpoint;
  logic [7:0] fault_status;
  wire logic bus_data_in = ~(host_oe | bus_data_oe); // Pull-up on the wire
  int num_errors = 0;
  int checked = 0;
  integer seed = 32'h46498013;
  logic [6:0] own;
  logic ack;
  logic [7:0] pec;
  logic [23:0] rtab [7] = '{{8'h01, 16'h0000}, {8'h02, 8'h00, RST_ON_OFF_SRC},
    {8'h10, 16'h0000}, {8'h19, 16'h00B0}, {8'h1B, 8'h00, RST_ALERT_MASK},
    {8'h20, 16'h0017}, {8'h21, 16'h0100}};
  // Config, operation, pin level, expected enable
  logic [17:0] otab [8] = '{{8'h16, 8'h00, 2'b00}, {8'h16, 8'h80, 2'b11},
    {8'h14, 8'h00, 2'b10}, {8'h14, 8'h00, 2'b01}, {8'h1E, 8'h00, 2'b10},
    {8'h1E, 8'h80, 2'b11}, {8'h1E, 8'h80, 2'b00}, {8'h06, 8'h00, 2'b01}};
  pms_slave dut (.*);
  pms_host host (.bus_clk(bus_clk), .host_oe(host_oe), .sda(bus_data_in));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    checked++;
    if (act !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : check
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ CRC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction : crc8
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    host.xbyte(d, q);
    host.bit_io(1'b1, q[0]);
    ack = ~q[0];
    pec = crc8(pec, d);
  endtask : put
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    host.xbyte(8'hFF, d);
    host.bit_io(last, r);
  endtask : get
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v,
                    input int n, input int pm);
    pec = 8'h00;
    host.start();
    put({a, 1'b0});
    put(c);
    for (int i = 0; i < n; i++) put(v[8*i +: 8]);
    if (pm > 0) put(pm == 1 ? pec : ~pec);
    host.stop();
    repeat (8) @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n,
                    output logic [15:0] v);
    logic [7:0] b;
    v = 16'h0000;
    host.start();
    put({a, 1'b0});
    put(c);
    host.start();
    put({a, 1'b1});
    for (int i = 0; i < n; i++) begin
      get(i == n - 1, b);
      v[8*i +: 8] = b;
    end
    host.stop();
    repeat (8) @(posedge clk_sys);
  endtask : rd
  task automatic ara(output logic [7:0] d);
    host.start();
    put({ALERT_RESP_ADDR, 1'b1});
    get(1'b1, d);
    host.stop();
    repeat (8) @(posedge clk_sys);
  endtask : ara
  task automatic rst(input logic [3:0] h, input logic [3:0] l);
    @(posedge clk_sys);
    address_strap_high_digit <= h;
    address_strap_low_digit <= l;
    resetn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    own = (h > 4'h7 || l > 4'h7) ? 7'h7F : {1'b0, h[2:0], l[2:0]};
  endtask : rst
  initial begin
    #1900000;
    num_errors++;
    conclude();
  end
  initial begin
    logic [15:0] v;
    logic [15:0] sp;
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      b = $random(seed);
      // Own address must differ from the alert response address
      if (b[5:0] == 6'h0C) b[0] = 1'b1;
      case (k)
        0: rst(4'h0, 4'h0);
        1: rst(4'h9, 4'h3);
        default: rst({1'b0, b[5:3]}, {1'b0, b[2:0]});
      endcase
      wr(own ^ 7'h01, CMD_OUT_ON_OFF, 16'h0000, 1, 0);
      check(ack, 1'b0);
      rd(own, CMD_FEATURES, 1, v);
      check(v, 16'h00B0);
    end
    check({fault_status, 7'h00, alert_oe}, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      rd(own, rtab[i][23:16], rtab[i][23:16] == CMD_SETPOINT ? 2 : 1, v);
      check(v, rtab[i][15:0]);
    end
    // Slow, fast, bad check byte, short count
    sp = 16'h0100;
    for (int p = 0; p < 4; p++) begin
      v = $random(seed);
      host.half_ns = p == 0 ? 5000 : (p == 1 ? 1250 : 250);
      wr(own, CMD_SETPOINT, v, p == 3 ? 1 : 2, p % 3);
      if (p < 2) sp = v;
      check(vout_setpoint, sp);
    end
    rd(own, CMD_SETPOINT, 2, v);
    check(v, sp);
    wr(own, CMD_FEATURES, 16'h0055, 1, 0);
    rd(own, CMD_FEATURES, 1, v);
    check(v, 16'h00B0);
    rd(own, CMD_FAULT_CLEAR, 1, v);
    check(v, 16'h00FF);
    wr(own, 8'h05, 16'h0000, 1, 0);
    check(ack, 1'b0);
    for (int i = 0; i < 8; i++) begin
      remote_on_off_input <= otab[i][1];
      wr(own, CMD_ON_OFF_SRC, {8'h00, otab[i][17:10]}, 1, 0);
      wr(own, CMD_OUT_ON_OFF, {8'h00, otab[i][9:2]}, 1, 0);
      check(conversion_enable, otab[i][0]);
    end
    ara(b);
    check(ack, 1'b0);
    fault_set <= 8'h01;
    repeat (8) @(posedge clk_sys);
    fault_set <= 8'h00;
    repeat (4) @(posedge clk_sys);
    check({fault_status, 7'h00, alert_oe}, 16'h0101);
    ara(b);
    check({ack, b}, {1'b1, own, 1'b0});
    check(alert_oe, 1'b0);
    wr(own, CMD_FAULT_CLEAR, 16'h0000, 0, 0);
    check({fault_status, 7'h00, alert_oe}, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      power_good_status <= 1'b0;
      repeat (8) @(posedge clk_sys);
      power_good_status <= 1'b1;
      check({fault_status, 7'h00, alert_oe}, {8'h08, 7'h00, m[0]});
      wr(own, CMD_FAULT_CLEAR, 16'h0000, 0, 0);
      check({fault_status, 7'h00, alert_oe}, 16'h0000);
      wr(own, CMD_ALERT_MASK, 16'h0000, 1, 0);
    end
    v = $random(seed);
    wr(own, CMD_SETPOINT, v, 2, 0);
    wr(own, CMD_SAVE_USER, 16'h0000, 0, 0);
    wr(own, CMD_SETPOINT, ~v, 2, 0);
    wr(own, CMD_LOAD_USER, 16'h0000, 0, 0);
    check(vout_setpoint, v);
    wr(own, CMD_WRITE_LOCK, {8'h00, LOCK_ALL}, 1, 0);
    wr(own, CMD_SETPOINT, ~v, 2, 0);
    wr(own, CMD_LOAD_FACTORY, 16'h0000, 0, 0);
    check(vout_setpoint, v);
    wr(own, CMD_WRITE_LOCK, 16'h0000, 1, 0);
    wr(own, CMD_LOAD_FACTORY, 16'h0000, 0, 0);
    check(vout_setpoint, 16'h0100);
    conclude();
  end
endmodule : testbench
bind pms_slave pms_monitor mon (.*);
